// File: include/phy_stat_pkg.sv
// Package: register map, field layout, timing counts and configuration and receive event types for the PHY statistics block
// Behaviour
// - Sixteen-bit disconnect counter adds one for every lost link.
// - Disconnect counter rolls over from all ones to zero.
// - False carrier counter adds one when carrier appears without a start pair.
// - False carrier counter holds at all ones until cleared.
// - Receive error counter rolls over from all ones to zero.
// - Read-only sixteen-bit silicon revision code is presented.
// - Config bit 15 enables NRZI coding, set after reset.
// - Config bit 14 picks descrambler timeout 2 ms or 722 us.
// - Descrambler timer bounds the window for receiving enough idle symbols.
// - Timer expiry drops descrambler sync and restarts the idle search.
// - Config bit 13 disables the descrambler timeout timer.
// - Config bit 12 selects repeater mode; carrier sense then follows receive only.
// - Node mode without full duplex raises carrier sense on receive or transmit.
// - Repeater bit loads from the strap pin on the first cycle after reset; management may overwrite.
package phy_stat_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [4:0] ADDR_DISCONNECT  = 5'h12;
  localparam logic [4:0] ADDR_FALSE_CARR  = 5'h13;
  localparam logic [4:0] ADDR_RX_ERROR    = 5'h15;
  localparam logic [4:0] ADDR_SI_REV      = 5'h16;
  localparam logic [4:0] ADDR_CODING_CFG  = 5'h17;

  // ************************************************************
  // Coding sublayer configuration fields and reset values
  // ************************************************************
  localparam int         CFG_NRZI_BIT     = 15;
  localparam int         CFG_TO_SEL_BIT   = 14;
  localparam int         CFG_TO_DIS_BIT   = 13;
  localparam int         CFG_REPEATER_BIT = 12;
  localparam logic       CFG_NRZI_RST     = 1'b1;
  localparam logic       CFG_TO_SEL_RST   = 1'b0;
  localparam logic       CFG_TO_DIS_RST   = 1'b0;
  localparam logic       CFG_REPEATER_RST = 1'b0;
  localparam logic [15:0] COUNT_RST       = 16'h0000;

  // ************************************************************
  // Management frame layout
  // ************************************************************
  localparam int         PREAMBLE_BITS    = 32;
  localparam int         HEADER_BITS      = 12;
  localparam int         DATA_BITS        = 16;
  localparam logic [1:0] OP_READ          = 2'b10;
  localparam logic [1:0] OP_WRITE         = 2'b01;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS     = 100;
  localparam int DESCR_TO_SHORT_NS = 722_000;
  localparam int DESCR_TO_LONG_NS  = 2_000_000;
  localparam int DESCR_SHORT_CYC   = DESCR_TO_SHORT_NS / CLK_PERIOD_NS;
  localparam int DESCR_LONG_CYC    = DESCR_TO_LONG_NS / CLK_PERIOD_NS;
  localparam int TIMER_W           = 16;
  localparam int CIM_LIMIT_DEF     = 8;

  // ************************************************************
  // Configuration and receive event types
  // ************************************************************
  typedef struct packed {
    logic nrzi_en;
    logic descrambler_timeout_select;
    logic descrambler_timeout_disable;
    logic repeater;
  } pcs_cfg_t;

  typedef struct packed {
    logic link_lost;      // One-cycle pulse per disconnect
    logic false_carrier;  // One-cycle pulse per false carrier event
    logic rx_dv;          // Receive packet in progress
    logic rx_er;          // Receive error during packet
    logic col;            // Collision seen
  } rx_events_t;

endpackage : phy_stat_pkg

// File: design/event_counter.sv
// Event counter with selectable wrap or saturation and clear
`timescale 1ns/100ps
`default_nettype none
module event_counter #(
  parameter int   W        = 16,
  parameter logic SATURATE = 1'b0
) (
  input  wire logic         i_mclk,    // Device clock
  input  wire logic         i_sys_rst, // Async reset, active high
  input  wire logic         i_inc,     // Count one event
  input  wire logic         i_clr,     // Clear count
  output logic [W-1:0]      o_count    // Current count
);

  // Clear and event in the same cycle leave a count of one, so the event is kept
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_count <= '0;
    end else if (i_clr) begin
      o_count <= i_inc ? W'(1) : '0;
    end else if (i_inc && !(SATURATE && (&o_count))) begin
      o_count <= o_count + W'(1);
    end
  end

endmodule : event_counter
`default_nettype wire

// File: design/descrambler_timer.sv
// Descrambler sync watchdog: expires when too few idles arrive within the window
`timescale 1ns/100ps
`default_nettype none
module descrambler_timer #(
  parameter int W = 16
) (
  input  wire logic         i_mclk,     // Device clock
  input  wire logic         i_sys_rst,  // Async reset, active high
  input  wire logic         i_disable,  // Timer held off
  input  wire logic [W-1:0] i_limit,    // Window length in cycles
  input  wire logic         i_idle_ok,  // Enough idles seen, restart window
  output logic              o_expire    // One-cycle pulse on expiry
);

  logic [W-1:0] count_q;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count_q  <= '0;
      o_expire <= 1'b0;
    end else if (i_disable || i_idle_ok) begin
      count_q  <= '0;
      o_expire <= 1'b0;
    end else if (count_q >= i_limit - W'(1)) begin
      count_q  <= '0;
      o_expire <= 1'b1;
    end else begin
      count_q  <= count_q + W'(1);
      o_expire <= 1'b0;
    end
  end

endmodule : descrambler_timer
`default_nettype wire

// File: design/phy_event_counters_pcs_config.sv
// Top: management registers, event counters and coding sublayer configuration
`timescale 1ns/100ps
`default_nettype none
module phy_event_counters_pcs_config #(
  parameter int          SHORT_CYC = phy_stat_pkg::DESCR_SHORT_CYC,
  parameter int          LONG_CYC  = phy_stat_pkg::DESCR_LONG_CYC,
  parameter int          CIM_LIMIT = phy_stat_pkg::CIM_LIMIT_DEF,
  parameter logic [15:0] SI_REV    = 16'h0001  // Arbitrary value
) (
  input  wire logic                     i_mclk,           // Device clock, 10 MHz
  input  wire logic                     i_sys_rst,        // Async reset, active high
  input  wire logic                     i_mdc,            // Management clock pin
  input  wire logic                     i_mdio,           // Management data pin in
  output logic                          o_mdio,           // Management data pin out
  output logic                          o_mdio_oe,        // Management data drive enable
  input  wire logic [4:0]               i_phy_addr,       // Station address straps
  input  wire logic                     i_repeater_strap, // Repeater strap pin
  input  wire phy_stat_pkg::rx_events_t i_ev,             // Receive path events
  input  wire logic                     i_cim_clr,        // Restart link stability check
  input  wire logic                     i_idle_ok,        // Enough idles seen in window
  input  wire logic                     i_rx_crs,         // Receive activity
  input  wire logic                     i_tx_en,          // Transmit activity
  input  wire logic                     i_full_duplex,    // Full duplex configured
  output phy_stat_pkg::pcs_cfg_t        o_cfg,            // Configuration to datapath
  output logic                          o_crs,            // Carrier sense to MAC
  output logic                          o_descr_restart,  // Descrambler restart pulse
  output logic                          o_cim_unstable    // Link judged unstable
);
  import phy_stat_pkg::*;

  typedef enum logic [2:0] {S_PRE, S_START, S_HDR, S_TA, S_WDATA, S_RDATA} mgmt_state_t;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [1:0] mdc_s_q;
  logic [1:0] mdio_s_q;
  logic [1:0] strap_s_q;
  logic [4:0] addr_s1_q;
  logic [4:0] addr_s2_q;
  logic       mdc_prev_q;
  logic       mdc_rise;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mdc_s_q    <= 2'h0;
      mdio_s_q   <= 2'h3;
      addr_s1_q  <= 5'h00;
      addr_s2_q  <= 5'h00;
      mdc_prev_q <= 1'b0;
    end else begin
      mdc_s_q    <= {mdc_s_q[0], i_mdc};
      mdio_s_q   <= {mdio_s_q[0], i_mdio};
      addr_s1_q  <= i_phy_addr;
      addr_s2_q  <= addr_s1_q;
      mdc_prev_q <= mdc_s_q[1];
    end
  end

  // Strap stages carry no reset so the pin level is through both of them at release
  always_ff @(posedge i_mclk) begin
    strap_s_q <= {strap_s_q[0], i_repeater_strap};
  end

  assign mdc_rise = mdc_s_q[1] & ~mdc_prev_q;

  // ************************************************************
  // Management frame engine
  // ************************************************************
  mgmt_state_t st_q;
  logic [5:0]  bit_cnt_q;
  logic [11:0] hdr_q;
  logic [15:0] shift_q;
  logic        is_read_q;
  logic        hit_q;
  logic [4:0]  reg_q;
  logic        fcs_rd_clr;
  logic        cfg_wr;
  logic [15:0] wr_data;
  logic [11:0] hdr_next;
  logic [15:0] dcnt;
  logic [15:0] fcnt;
  logic [15:0] rxecnt;

  // Register read decode; unmapped and left-out bits read zero
  function automatic logic [15:0] read_reg(input logic [4:0] a, input pcs_cfg_t c,
                                           input logic [15:0] d, input logic [15:0] f,
                                           input logic [15:0] r);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      ADDR_DISCONNECT: v = d;
      ADDR_FALSE_CARR: v = f;
      ADDR_RX_ERROR:   v = r;
      ADDR_SI_REV:     v = SI_REV;
      ADDR_CODING_CFG: v = {c, 12'h000};
      default:         v = 16'h0000;
    endcase
    return v;
  endfunction : read_reg

  assign hdr_next = {hdr_q[10:0], mdio_s_q[1]};
  assign wr_data  = {shift_q[14:0], mdio_s_q[1]};

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q      <= S_PRE;
      bit_cnt_q <= 6'h00;
      hdr_q     <= 12'h000;
      shift_q   <= 16'h0000;
      is_read_q <= 1'b0;
      hit_q     <= 1'b0;
      reg_q     <= 5'h00;
      o_mdio    <= 1'b1;
      o_mdio_oe <= 1'b0;
    end else if (mdc_rise) begin
      case (st_q)
        S_PRE: begin
          if (!mdio_s_q[1]) begin
            bit_cnt_q <= 6'h00;
            st_q      <= (bit_cnt_q >= 6'(PREAMBLE_BITS)) ? S_START : S_PRE;
          end else if (bit_cnt_q < 6'(PREAMBLE_BITS)) begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
          end
        end
        S_START: begin
          bit_cnt_q <= 6'h00;
          st_q      <= mdio_s_q[1] ? S_HDR : S_PRE;
        end
        S_HDR: begin
          hdr_q     <= hdr_next;
          bit_cnt_q <= bit_cnt_q + 6'h01;
          if (bit_cnt_q == 6'(HEADER_BITS - 1)) begin
            is_read_q <= (hdr_next[11:10] == OP_READ);
            hit_q     <= (hdr_next[9:5] == addr_s2_q) &&
                         ((hdr_next[11:10] == OP_READ) || (hdr_next[11:10] == OP_WRITE));
            reg_q     <= hdr_next[4:0];
            shift_q   <= read_reg(hdr_next[4:0], o_cfg, dcnt, fcnt, rxecnt);
            bit_cnt_q <= 6'h00;
            st_q      <= S_TA;
          end
        end
        S_TA: begin
          bit_cnt_q <= bit_cnt_q + 6'h01;
          if (bit_cnt_q == 6'h00) begin
            o_mdio_oe <= is_read_q && hit_q;
            o_mdio    <= !(is_read_q && hit_q);
          end else begin
            bit_cnt_q <= 6'h00;
            // Data out idles high whenever the line is not ours
            o_mdio    <= shift_q[15] | !(is_read_q && hit_q);
            shift_q   <= is_read_q ? {shift_q[14:0], 1'b0} : shift_q;
            st_q      <= is_read_q ? S_RDATA : S_WDATA;
          end
        end
        S_RDATA: begin
          bit_cnt_q <= bit_cnt_q + 6'h01;
          o_mdio    <= shift_q[15] | !hit_q;
          shift_q   <= {shift_q[14:0], 1'b0};
          if (bit_cnt_q == 6'(DATA_BITS - 1)) begin
            o_mdio_oe <= 1'b0;
            o_mdio    <= 1'b1;
            bit_cnt_q <= 6'h00;
            st_q      <= S_PRE;
          end
        end
        S_WDATA: begin
          bit_cnt_q <= bit_cnt_q + 6'h01;
          shift_q   <= wr_data;
          if (bit_cnt_q == 6'(DATA_BITS - 1)) begin
            bit_cnt_q <= 6'h00;
            st_q      <= S_PRE;
          end
        end
        default: begin
          st_q      <= S_PRE;
          o_mdio_oe <= 1'b0;
          o_mdio    <= 1'b1;
        end
      endcase
    end
  end

  // Clear is taken when the read value is captured, so no event is lost in between
  assign fcs_rd_clr = mdc_rise && (st_q == S_HDR) && (bit_cnt_q == 6'(HEADER_BITS - 1)) &&
                      (hdr_next[11:10] == OP_READ) && (hdr_next[9:5] == addr_s2_q) &&
                      (hdr_next[4:0] == ADDR_FALSE_CARR);

  // Only the configuration register accepts writes
  assign cfg_wr = mdc_rise && (st_q == S_WDATA) && (bit_cnt_q == 6'(DATA_BITS - 1)) &&
                  hit_q && (reg_q == ADDR_CODING_CFG);

  // ************************************************************
  // Configuration register
  // ************************************************************
  logic strap_done_q;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cfg.nrzi_en                     <= CFG_NRZI_RST;
      o_cfg.descrambler_timeout_select  <= CFG_TO_SEL_RST;
      o_cfg.descrambler_timeout_disable <= CFG_TO_DIS_RST;
      o_cfg.repeater                    <= CFG_REPEATER_RST;
      strap_done_q                      <= 1'b0;
    end else if (cfg_wr) begin
      o_cfg.nrzi_en                     <= wr_data[CFG_NRZI_BIT];
      o_cfg.descrambler_timeout_select  <= wr_data[CFG_TO_SEL_BIT];
      o_cfg.descrambler_timeout_disable <= wr_data[CFG_TO_DIS_BIT];
      o_cfg.repeater                    <= wr_data[CFG_REPEATER_BIT];
      strap_done_q                      <= 1'b1;
    end else if (!strap_done_q) begin
      // Strap level has settled through both stages while reset was held
      o_cfg.repeater <= strap_s_q[1];
      strap_done_q   <= 1'b1;
    end
  end

  // ************************************************************
  // Event counters
  // ************************************************************
  logic rx_dv_q;
  logic rx_err_seen_q;
  logic rx_col_seen_q;
  logic rx_pkt_err;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_dv_q       <= 1'b0;
      rx_err_seen_q <= 1'b0;
      rx_col_seen_q <= 1'b0;
    end else begin
      rx_dv_q <= i_ev.rx_dv;
      if (i_ev.rx_dv && !rx_dv_q) begin
        rx_err_seen_q <= i_ev.rx_er;
        rx_col_seen_q <= i_ev.col;
      end else if (i_ev.rx_dv) begin
        rx_err_seen_q <= rx_err_seen_q | i_ev.rx_er;
        rx_col_seen_q <= rx_col_seen_q | i_ev.col;
      end
    end
  end

  // One count per errored packet, at its end, only if collision-free
  assign rx_pkt_err = rx_dv_q && !i_ev.rx_dv && rx_err_seen_q && !rx_col_seen_q;

  event_counter #(.W(16), .SATURATE(1'b0)) u_disc_cnt (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_inc     (i_ev.link_lost),
    .i_clr     (1'b0),
    .o_count   (dcnt)
  );

  event_counter #(.W(16), .SATURATE(1'b1)) u_fcs_cnt (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_inc     (i_ev.false_carrier),
    .i_clr     (fcs_rd_clr),
    .o_count   (fcnt)
  );

  event_counter #(.W(16), .SATURATE(1'b0)) u_rxe_cnt (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_inc     (rx_pkt_err),
    .i_clr     (1'b0),
    .o_count   (rxecnt)
  );

  // ************************************************************
  // Carrier integrity monitor, separate from the readable counter
  // ************************************************************
  logic [15:0] cim_cnt;

  event_counter #(.W(16), .SATURATE(1'b1)) u_cim_cnt (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_inc     (i_ev.false_carrier),
    .i_clr     (i_cim_clr),
    .o_count   (cim_cnt)
  );

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cim_unstable <= 1'b0;
    end else begin
      o_cim_unstable <= (cim_cnt >= 16'(CIM_LIMIT));
    end
  end

  // ************************************************************
  // Descrambler timeout and carrier sense
  // ************************************************************
  logic [TIMER_W-1:0] to_limit;

  assign to_limit = o_cfg.descrambler_timeout_select ? TIMER_W'(LONG_CYC)
                                                     : TIMER_W'(SHORT_CYC);

  descrambler_timer #(.W(TIMER_W)) u_descr_to (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_disable (o_cfg.descrambler_timeout_disable),
    .i_limit   (to_limit),
    .i_idle_ok (i_idle_ok),
    .o_expire  (o_descr_restart)
  );

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_crs <= 1'b0;
    end else if (o_cfg.repeater || i_full_duplex) begin
      o_crs <= i_rx_crs;
    end else begin
      o_crs <= i_rx_crs | i_tx_en;
    end
  end

endmodule : phy_event_counters_pcs_config
`default_nettype wire

// File: sim/phy_stat_chk.sv
// Checker: port-level assertions for the statistics and configuration block
`timescale 1ns/100ps
`default_nettype none
module phy_stat_chk (
  input wire logic                     i_mclk,          // Device clock
  input wire logic                     i_sys_rst,       // Async reset
  input wire phy_stat_pkg::rx_events_t i_ev,            // Receive events
  input wire logic                     i_cim_clr,       // Monitor clear
  input wire logic                     i_idle_ok,       // Idle window restart
  input wire logic                     i_rx_crs,        // Receive activity
  input wire logic                     i_tx_en,         // Transmit activity
  input wire logic                     i_full_duplex,   // Full duplex
  input wire phy_stat_pkg::pcs_cfg_t   o_cfg,           // Configuration
  input wire logic                     o_crs,           // Carrier sense
  input wire logic                     o_mdio,          // Data out
  input wire logic                     o_mdio_oe,       // Drive enable
  input wire logic                     o_descr_restart, // Restart pulse
  input wire logic                     o_cim_unstable   // Unstable flag
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  chk_crs_rx_only: assert property (
    (o_cfg.repeater || i_full_duplex) |=> o_crs == $past(i_rx_crs))
    else $error("carrier sense not following receive only");
  chk_crs_either: assert property (
    (!o_cfg.repeater && !i_full_duplex) |=> o_crs == $past(i_rx_crs || i_tx_en))
    else $error("carrier sense not following receive or transmit");
  chk_restart_spacing: assert property (
    o_descr_restart |=> !o_descr_restart [*8])
    else $error("restart pulse too long or too close");
  chk_timer_held: assert property (
    o_cfg.descrambler_timeout_disable [*2] |-> !o_descr_restart)
    else $error("restart while timer disabled");
  chk_idle_window: assert property (
    i_idle_ok |-> ##2 !o_descr_restart [*7])
    else $error("restart right after idle window restart");
  chk_mdio_idle: assert property (
    !o_mdio_oe |-> o_mdio)
    else $error("data out not idle high");
  chk_cim_kept: assert property (
    (o_cim_unstable && !i_cim_clr && !$past(i_cim_clr)) |=> o_cim_unstable)
    else $error("unstable flag dropped without monitor clear");
  chk_cim_cause: assert property (
    $rose(o_cim_unstable) |-> ($past(i_ev.false_carrier) || $past(i_ev.false_carrier, 2)))
    else $error("unstable flag rose without false carrier");
endmodule : phy_stat_chk
bind phy_event_counters_pcs_config phy_stat_chk u_chk (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ev(i_ev), .i_cim_clr(i_cim_clr),
  .i_idle_ok(i_idle_ok), .i_rx_crs(i_rx_crs), .i_tx_en(i_tx_en),
  .i_full_duplex(i_full_duplex), .o_cfg(o_cfg), .o_crs(o_crs), .o_mdio(o_mdio),
  .o_mdio_oe(o_mdio_oe), .o_descr_restart(o_descr_restart),
  .o_cim_unstable(o_cim_unstable));
`default_nettype wire

// File: sim/mgmt_station.sv
// Station management model: drives management frames and samples read data
`timescale 1ns/100ps
`default_nettype none
module mgmt_station #(
  parameter logic [4:0] PHY = 5'h01
) (
  input  wire logic i_mclk,    // Device clock
  input  wire logic i_mdio,    // Resolved data line
  output logic      o_mdc,     // Management clock
  output logic      o_mdio,    // Data driven by station
  output logic      o_mdio_oe  // Station drive enable
);
  import phy_stat_pkg::*;
  // ********
  // Frame engine
  // ********
  initial begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_mdio_oe = 1'b0;
  end
  // Five device cycles per half period keeps the clock well inside the sync margin
  task automatic half();
    repeat (5) @(posedge i_mclk);
    #1;
  endtask : half
  task automatic bit_cyc(input logic b, output logic s);
    o_mdc = 1'b0;
    o_mdio = b;
    half();
    o_mdc = 1'b1;
    s = i_mdio;
    half();
  endtask : bit_cyc
  task automatic frame(input logic [1:0] op, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [45:0] hdr;
    logic        s;
    hdr = {32'hFFFF_FFFF, 2'b01, op, PHY, ra};
    rd = 16'h0000;
    o_mdio_oe = 1'b1;
    for (int i = 45; i >= 0; i--) bit_cyc(hdr[i], s);
    // Line released for reads so the device owns turnaround and data
    o_mdio_oe = (op == OP_WRITE);
    bit_cyc(1'b1, s);
    bit_cyc(1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(wd[i], s);
      rd[i] = s;
    end
    o_mdio_oe = 1'b0;
    o_mdio = 1'b1;
    o_mdc = 1'b0;
  endtask : frame
endmodule : mgmt_station
`default_nettype wire

// File: sim/test_phy_event_counters_pcs_config.sv
// Testbench: management reads and writes with event stimulus for the statistics block
`timescale 1ns/100ps
`default_nettype none
module test_phy_event_counters_pcs_config;
  import phy_stat_pkg::*;
  localparam logic [15:0] REV = 16'h5A3C;  // Arbitrary revision value
  localparam int          SH  = 20;
  localparam int          LG  = 50;
  localparam logic [4:0]  RO_A [4] = '{ADDR_DISCONNECT, ADDR_FALSE_CARR, ADDR_RX_ERROR, ADDR_SI_REV};
  localparam logic [15:0] RO_E [4] = '{16'h0000, 16'h0000, 16'h0000, REV};
  logic        clk, rst, mdc, sta_mdio, sta_oe, dut_mdio, dut_oe, strap;
  logic        cim_clr, idle_ok, rx_crs, tx_en, fd, crs, restart, unstable;
  wire logic   mdio_w;
  rx_events_t  ev;
  pcs_cfg_t    cfg;
  logic [15:0] rdv;
  int          g, n_mismatch, cmp_count;
  // Released line floats to its pull-up level
  assign mdio_w = dut_oe ? dut_mdio : (sta_oe ? sta_mdio : 1'b1);
  phy_event_counters_pcs_config #(.SHORT_CYC(SH), .LONG_CYC(LG), .CIM_LIMIT(4), .SI_REV(REV)) uut (
    .i_mclk(clk), .i_sys_rst(rst), .i_mdc(mdc), .i_mdio(mdio_w), .o_mdio(dut_mdio),
    .o_mdio_oe(dut_oe), .i_phy_addr(5'h01), .i_repeater_strap(strap), .i_ev(ev),
    .i_cim_clr(cim_clr), .i_idle_ok(idle_ok), .i_rx_crs(rx_crs), .i_tx_en(tx_en),
    .i_full_duplex(fd), .o_cfg(cfg), .o_crs(crs), .o_descr_restart(restart),
    .o_cim_unstable(unstable));
  mgmt_station #(.PHY(5'h01)) u_sta (.i_mclk(clk), .i_mdio(mdio_w), .o_mdc(mdc),
    .o_mdio(sta_mdio), .o_mdio_oe(sta_oe));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ********
  // Shared tasks
  // ********
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    u_sta.frame(OP_READ, ra, 16'h0000, rdv);
    cmp(rdv, exp);
  endtask : rd
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    u_sta.frame(OP_WRITE, ra, d, rdv);
  endtask : wr
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  task automatic next_restart(output int n);
    n = 0;
    while (restart !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    if (n >= 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask : next_restart
  // Spacing of free-running restarts; one cycle of slack for the reload
  task automatic period(input int lim);
    next_restart(g);
    tick(1);
    next_restart(g);
    cmp(16'(g + 1 >= lim && g + 1 <= lim + 1), 16'h0001);
  endtask : period
  // ********
  // Sequence
  // ********
  initial begin
    {cim_clr, idle_ok, rx_crs, tx_en, fd} = 5'h00;
    ev = '0;
    strap = 1'b1;
    n_mismatch = 0;
    cmp_count = 0;
    rst = 1'b1;
    tick(10);
    rst = 1'b0;
    tick(5);
    rd(ADDR_CODING_CFG, 16'h9000);
    cmp(16'(cfg), 16'h0009);
    for (int i = 0; i < 4; i++) rd(RO_A[i], RO_E[i]);
    for (int i = 0; i < 4; i++) wr(RO_A[i], 16'hFFFF);
    for (int i = 0; i < 4; i++) rd(RO_A[i], RO_E[i]);
    wr(ADDR_CODING_CFG, 16'h6FFF);
    rd(ADDR_CODING_CFG, 16'h6000);
    cmp(16'(cfg), 16'h0006);
    tx_en = 1'b1;
    tick(2);
    cmp(16'(crs), 16'h0001);
    fd = 1'b1;
    tick(2);
    cmp(16'(crs), 16'h0000);
    wr(ADDR_CODING_CFG, 16'h1000);
    fd = 1'b0;
    tick(2);
    cmp(16'(crs), 16'h0000);
    rx_crs = 1'b1;
    tick(2);
    cmp(16'(crs), 16'h0001);
    {rx_crs, tx_en} = 2'b00;
    period(SH);
    idle_ok = 1'b1;
    tick(1);
    idle_ok = 1'b0;
    wr(ADDR_CODING_CFG, 16'h5000);
    period(LG);
    wr(ADDR_CODING_CFG, 16'h3000);
    g = 0;
    repeat (200) begin
      tick(1);
      if (restart === 1'b1) g++;
    end
    cmp(16'(g), 16'h0000);
    ev.link_lost = 1'b1;
    ev.false_carrier = 1'b1;
    tick(65535);
    ev = '0;
    rd(ADDR_DISCONNECT, 16'hFFFF);
    ev.link_lost = 1'b1;
    ev.false_carrier = 1'b1;
    tick(1);
    ev = '0;
    rd(ADDR_DISCONNECT, 16'h0000);
    rd(ADDR_FALSE_CARR, 16'hFFFF);
    cim_clr = 1'b1;
    tick(1);
    cim_clr = 1'b0;
    tick(3);
    cmp(16'(unstable), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      ev.rx_dv = 1'b1;
      ev.rx_er = (i != 2);
      ev.col = (i == 3);
      tick(3);
      ev = '0;
      tick(3);
    end
    rd(ADDR_RX_ERROR, 16'h0002);
    repeat (4) begin
      ev.false_carrier = 1'b1;
      tick(1);
      ev.false_carrier = 1'b0;
      tick(1);
    end
    tick(2);
    cmp(16'(unstable), 16'h0001);
    rd(ADDR_FALSE_CARR, 16'h0004);
    rd(ADDR_FALSE_CARR, 16'h0000);
    cmp(16'(unstable), 16'h0001);
    cim_clr = 1'b1;
    tick(1);
    cim_clr = 1'b0;
    tick(3);
    cmp(16'(unstable), 16'h0000);
    tally_and_finish();
  end
endmodule : test_phy_event_counters_pcs_config
`default_nettype wire
